// >>> verilog/rx_ring_pkg.sv
// Purpose: shared constants and types for the receive ring host controller
// Assumes: 16-bit shared memory words, 24-bit byte addresses
// Notes:   descriptor field positions and ring limits live here only
package rx_ring_pkg;

   // descriptor layout
   localparam int unsigned DESC_WORDS   = 4;
   localparam int unsigned RING_MAX     = 128;
   localparam int unsigned OWN_BIT      = 15;
   localparam int unsigned EOR_BIT      = 14;
   localparam int unsigned RSVD_BIT     = 13;
   localparam int unsigned LAST_BIT     = 12;
   localparam int unsigned TYPE_LSB     = 9;
   localparam int unsigned ERR_BIT      = 8;
   localparam int unsigned ADDR_HI_MSB  = 7;
   localparam logic [1:0]  WORD_CTRL    = 2'h0;
   localparam logic [1:0]  WORD_ADDR_LO = 2'h1;
   localparam logic [1:0]  WORD_LEN     = 2'h2;
   localparam logic [1:0]  WORD_MSG_LEN = 2'h3;
   localparam logic [15:0] MIN_BUF_LEN  = 16'h000e;
   localparam logic [15:0] SAFE_BUF_LEN = 16'h0010;
   localparam logic [7:0]  POLL_GAP     = 8'h10;

   // frame type codes written back by the device
   localparam logic [2:0]  FT_SWITCHED_CIRCUIT_FRAME = 3'h0;
   localparam logic [2:0]  FT_FULL_ENQ               = 3'h2;
   localparam logic [2:0]  FT_ENQ_LINK_INTEGRITY     = 3'h3;
   localparam logic [2:0]  FT_ASYNC_STATUS           = 3'h4;
   localparam logic [2:0]  FT_UPDATE_STATUS          = 3'h5;
   localparam logic [2:0]  FT_FULL_STATUS            = 3'h6;
   localparam logic [2:0]  FT_STATUS_LINK_INTEGRITY  = 3'h7;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_INIT_WR,
      ST_INIT_WAIT,
      ST_POLL,
      ST_POLL_WAIT,
      ST_CNT_WAIT,
      ST_HOLD,
      ST_GIVE_WAIT
   } host_state_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [23:0] addr;
      logic [15:0] wdata;
   } mem_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        error;
      logic        last;
      logic [2:0]  ftype;
      logic [6:0]  index;
      logic [15:0] bytes;
   } rx_report_t;

endpackage : rx_ring_pkg

// >>> verilog/rx_mem_port.sv
// Purpose: single-word request/acknowledge master toward shared memory
// Assumes: memory holds i_mem_ack high for one cycle per completed access
// Notes:   one access in flight; a new command while busy is dropped
module rx_mem_port (
   // clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   // command from the ring engine
   input  wire rx_ring_pkg::mem_cmd_t i_cmd,
   output logic                       o_done,
   output logic [15:0]                o_rdata,
   // shared memory side
   output logic                       o_mem_req,
   output logic                       o_mem_we,
   output logic [23:0]                o_mem_addr,
   output logic [15:0]                o_mem_wdata,
   input  wire logic                  i_mem_ack,
   input  wire logic [15:0]           i_mem_rdata
);

   typedef struct packed {
      rx_ring_pkg::mem_cmd_t cmd;
      logic                  done;
      logic [15:0]           rdata;
   } port_regs_t;

   port_regs_t s_q;
   port_regs_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (!s_q.cmd.req && i_cmd.req) begin
         s_d.cmd = i_cmd;
      end else if (s_q.cmd.req && i_mem_ack) begin
         s_d.cmd.req = 1'b0;
         s_d.done    = 1'b1;
         s_d.rdata   = i_mem_rdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_done      = s_q.done;
   assign o_rdata     = s_q.rdata;
   assign o_mem_req   = s_q.cmd.req;
   assign o_mem_we    = s_q.cmd.we;
   assign o_mem_addr  = s_q.cmd.addr;
   assign o_mem_wdata = s_q.cmd.wdata;

   // request held until acknowledged
   req_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
      else $error("memory request dropped before acknowledge");

endmodule : rx_mem_port

// >>> verilog/rx_ring_host.sv
// Purpose: host side of one receive descriptor ring on a management channel
// Assumes: device fills buffers by DMA and hands descriptors back
// Notes:   descriptors are polled; there is no interrupt path
//
// Notes on behaviour
// - ownership bit 15 one gives descriptor to device; host sets it after emptying.
// - a ring holds at most 128 descriptors of four 16-bit words each.
// - host sets end-of-ring bit 14 only in the last descriptor.
// - host writes reserved bit 13 of word 0 as zero.
// - error bit counts only when keep-bad-frames is enabled; otherwise ignored.
// - host writes upper buffer address in bits 7:0; device never alters it.
// - host writes low buffer address in word 1; device never alters it.
// - every receive buffer starts on a word-aligned address.
// - word 2 holds negated buffer length; device leaves it unchanged.
// - buffer length must be an even byte count.
// - management channel buffers should be longer than 14 bytes.
// - word 3 length valid only with last-buffer set; else buffer length applies.
module rx_ring_host (
   // clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst,
   // user orders
   input  wire logic                    i_start,
   input  wire logic [6:0]              i_ring_last,
   input  wire logic [23:0]             i_ring_base,
   input  wire logic [23:0]             i_buf_base,
   input  wire logic [15:0]             i_buf_len,
   input  wire logic                    i_keep_bad_frames_enable,
   input  wire logic                    i_release,
   // user results
   output rx_ring_pkg::rx_report_t     o_rx,
   output logic                         o_busy,
   // shared memory
   output logic                         o_mem_req,
   output logic                         o_mem_we,
   output logic [23:0]                  o_mem_addr,
   output logic [15:0]                  o_mem_wdata,
   input  wire logic                    i_mem_ack,
   input  wire logic [15:0]             i_mem_rdata
);

   typedef struct packed {
      rx_ring_pkg::host_state_t st;
      logic [6:0]               idx;
      logic [6:0]               last;
      logic [1:0]               wsel;
      logic [23:0]              ring_base;
      logic [23:0]              buf_addr;
      logic [15:0]              len;
      logic [15:0]              ctrl;
      logic                     keep_bad;
      logic [7:0]               gap;
      logic                     busy;
      rx_ring_pkg::mem_cmd_t    cmd;
      rx_ring_pkg::rx_report_t  rpt;
   } host_regs_t;

   host_regs_t  s_q;
   host_regs_t  s_d;
   logic        mem_done;
   logic [15:0] mem_rdata;
   logic [15:0] len_even;
   logic [23:0] desc_addr;

   rx_mem_port u_port (
      .i_ref_clk   (i_ref_clk),
      .i_rst       (i_rst),
      .i_cmd       (s_q.cmd),
      .o_done      (mem_done),
      .o_rdata     (mem_rdata),
      .o_mem_req   (o_mem_req),
      .o_mem_we    (o_mem_we),
      .o_mem_addr  (o_mem_addr),
      .o_mem_wdata (o_mem_wdata),
      .i_mem_ack   (i_mem_ack),
      .i_mem_rdata (i_mem_rdata)
   );

   // short buffers are widened, a frame header must fit one buffer
   always_comb begin
      len_even = {i_buf_len[15:1], 1'b0};
      if (len_even <= rx_ring_pkg::MIN_BUF_LEN) begin
         len_even = rx_ring_pkg::SAFE_BUF_LEN;
      end
   end

   // four words of two bytes, eight bytes per slot
   assign desc_addr = s_q.ring_base + {14'h0000, s_q.idx, 3'h0};

   always_comb begin
      s_d           = s_q;
      s_d.cmd.req   = 1'b0;
      s_d.rpt.valid = 1'b0;
      unique case (s_q.st)
         rx_ring_pkg::ST_IDLE: begin
            if (i_start) begin
               s_d.idx       = 7'h00;
               s_d.last      = i_ring_last;
               s_d.wsel      = rx_ring_pkg::WORD_ADDR_LO;
               s_d.ring_base = {i_ring_base[23:1], 1'b0};
               s_d.buf_addr  = {i_buf_base[23:1], 1'b0};
               s_d.len       = len_even;
               s_d.keep_bad  = i_keep_bad_frames_enable;
               s_d.busy      = 1'b1;
               s_d.st        = rx_ring_pkg::ST_INIT_WR;
            end
         end
         rx_ring_pkg::ST_INIT_WR: begin
            s_d.cmd.req  = 1'b1;
            s_d.cmd.we   = 1'b1;
            s_d.cmd.addr = desc_addr + {21'h000000, s_q.wsel, 1'b0};
            unique case (s_q.wsel)
               rx_ring_pkg::WORD_ADDR_LO: s_d.cmd.wdata = {s_q.buf_addr[15:1], 1'b0};
               rx_ring_pkg::WORD_LEN:     s_d.cmd.wdata = 16'h0000 - s_q.len;
               rx_ring_pkg::WORD_MSG_LEN: s_d.cmd.wdata = 16'h0000;
               rx_ring_pkg::WORD_CTRL: begin
                  s_d.cmd.wdata                           = 16'h0000;
                  s_d.cmd.wdata[rx_ring_pkg::OWN_BIT]     = 1'b1;
                  s_d.cmd.wdata[rx_ring_pkg::EOR_BIT]     = (s_q.idx == s_q.last);
                  s_d.cmd.wdata[rx_ring_pkg::ADDR_HI_MSB:0] = s_q.buf_addr[23:16];
               end
            endcase
            s_d.st = rx_ring_pkg::ST_INIT_WAIT;
         end
         rx_ring_pkg::ST_INIT_WAIT: begin
            // ownership word goes last, so the device never sees a half-built slot
            if (mem_done) begin
               s_d.st   = rx_ring_pkg::ST_INIT_WR;
               s_d.wsel = s_q.wsel + 2'h1;
               if (s_q.wsel == rx_ring_pkg::WORD_CTRL) begin
                  s_d.wsel     = rx_ring_pkg::WORD_ADDR_LO;
                  s_d.buf_addr = s_q.buf_addr + {8'h00, s_q.len};
                  s_d.idx      = s_q.idx + 7'h01;
                  if (s_q.idx == s_q.last) begin
                     s_d.idx = 7'h00;
                     s_d.gap = 8'h00;
                     s_d.st  = rx_ring_pkg::ST_POLL;
                  end
               end
            end
         end
         rx_ring_pkg::ST_POLL: begin
            // spacing keeps polling from starving the device's DMA
            if (s_q.gap != 8'h00) begin
               s_d.gap = s_q.gap - 8'h01;
            end else begin
               s_d.cmd.req  = 1'b1;
               s_d.cmd.we   = 1'b0;
               s_d.cmd.addr = desc_addr;
               s_d.st       = rx_ring_pkg::ST_POLL_WAIT;
            end
         end
         rx_ring_pkg::ST_POLL_WAIT: begin
            if (mem_done) begin
               s_d.ctrl = mem_rdata;
               if (mem_rdata[rx_ring_pkg::OWN_BIT]) begin
                  s_d.gap = rx_ring_pkg::POLL_GAP;
                  s_d.st  = rx_ring_pkg::ST_POLL;
               end else begin
                  s_d.cmd.req  = 1'b1;
                  s_d.cmd.we   = 1'b0;
                  s_d.cmd.addr = desc_addr + (mem_rdata[rx_ring_pkg::LAST_BIT] ?
                                 {21'h000000, rx_ring_pkg::WORD_MSG_LEN, 1'b0} :
                                 {21'h000000, rx_ring_pkg::WORD_LEN, 1'b0});
                  s_d.st       = rx_ring_pkg::ST_CNT_WAIT;
               end
            end
         end
         rx_ring_pkg::ST_CNT_WAIT: begin
            if (mem_done) begin
               s_d.rpt.valid = 1'b1;
               s_d.rpt.last  = s_q.ctrl[rx_ring_pkg::LAST_BIT];
               s_d.rpt.ftype = s_q.ctrl[rx_ring_pkg::TYPE_LSB +: 3];
               s_d.rpt.error = s_q.ctrl[rx_ring_pkg::ERR_BIT] & s_q.keep_bad;
               s_d.rpt.index = s_q.idx;
               s_d.rpt.bytes = 16'h0000 - mem_rdata;
               s_d.st        = rx_ring_pkg::ST_HOLD;
            end
         end
         rx_ring_pkg::ST_HOLD: begin
            if (i_release) begin
               s_d.cmd.req   = 1'b1;
               s_d.cmd.we    = 1'b1;
               s_d.cmd.addr  = desc_addr;
               s_d.cmd.wdata = {1'b1, s_q.ctrl[rx_ring_pkg::EOR_BIT], 6'h00,
                                s_q.ctrl[rx_ring_pkg::ADDR_HI_MSB:0]};
               s_d.st        = rx_ring_pkg::ST_GIVE_WAIT;
            end
         end
         rx_ring_pkg::ST_GIVE_WAIT: begin
            if (mem_done) begin
               s_d.idx = s_q.ctrl[rx_ring_pkg::EOR_BIT] ? 7'h00 : s_q.idx + 7'h01;
               s_d.gap = 8'h00;
               s_d.st  = rx_ring_pkg::ST_POLL;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rx   = s_q.rpt;
   assign o_busy = s_q.busy;

   sequence ctrl_write_s;
      o_mem_req && o_mem_we && (o_mem_addr[2:1] == rx_ring_pkg::WORD_CTRL);
   endsequence

   sequence give_back_s;
      (s_q.st == rx_ring_pkg::ST_HOLD) && i_release ##1 s_q.cmd.req;
   endsequence

   give_owner_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      give_back_s |-> s_q.cmd.wdata[rx_ring_pkg::OWN_BIT] && s_q.cmd.we)
      else $error("descriptor returned without ownership bit");

   ring_bound_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_q.busy |-> s_q.idx <= s_q.last)
      else $error("ring index beyond last descriptor");

   eor_last_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_q.st == rx_ring_pkg::ST_INIT_WAIT) && s_q.cmd.req && (s_q.wsel == rx_ring_pkg::WORD_CTRL)
      |-> s_q.cmd.wdata[rx_ring_pkg::EOR_BIT] == (s_q.idx == s_q.last))
      else $error("end-of-ring bit on wrong descriptor");

   rsvd_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ctrl_write_s |-> !o_mem_wdata[rx_ring_pkg::RSVD_BIT])
      else $error("reserved control bit written as one");

   err_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_rx.valid && !s_q.keep_bad |-> !o_rx.error)
      else $error("frame error reported while bad frames are not kept");

   addr_align_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_mem_req && o_mem_we && (o_mem_addr[2:1] == rx_ring_pkg::WORD_ADDR_LO) |-> !o_mem_wdata[0])
      else $error("buffer address not word aligned");

   len_even_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_mem_req && o_mem_we && (o_mem_addr[2:1] == rx_ring_pkg::WORD_LEN)
      |-> !o_mem_wdata[0] && ((16'h0000 - o_mem_wdata) > rx_ring_pkg::MIN_BUF_LEN))
      else $error("buffer length odd or too short");

   wrap_first_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_q.st == rx_ring_pkg::ST_GIVE_WAIT) && mem_done && s_q.ctrl[rx_ring_pkg::EOR_BIT]
      |=> (s_q.idx == 7'h00) && (s_q.st == rx_ring_pkg::ST_POLL)
          ##1 s_q.cmd.req && !s_q.cmd.we && (s_q.cmd.addr == s_q.ring_base))
      else $error("ring did not wrap to first descriptor");

   report_src_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (s_q.st == rx_ring_pkg::ST_POLL_WAIT) && mem_done && !mem_rdata[rx_ring_pkg::OWN_BIT]
      |-> ##2 o_mem_req && !o_mem_we
          && (o_mem_addr[2:1] == ($past(mem_rdata[rx_ring_pkg::LAST_BIT], 2) ? rx_ring_pkg::WORD_MSG_LEN
                                                                               : rx_ring_pkg::WORD_LEN)))
      else $error("byte count read from wrong word");

endmodule : rx_ring_host

// >>> tb/rx_dev_model.sv
// Purpose: behavioural receiving device plus shared memory for the ring host
// Assumes: descriptor ring lies below byte address 0x2000
// Notes:   fill is called by the bench to stand for one received buffer
module rx_dev_model (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // shared memory port
   input  wire logic        i_mem_req,
   input  wire logic        i_mem_we,
   input  wire logic [23:0] i_mem_addr,
   input  wire logic [15:0] i_mem_wdata,
   output logic             o_mem_ack,
   output logic [15:0]      o_mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [0:4095];
   logic [11:0] ring_w;
   int          dev_idx;
   int          slow;
   int          wait_cnt;

   initial begin
      o_mem_rdata = 16'h5a5a;
      slow        = 0;
   end

   // empty memory, device restarts at descriptor 0
   task automatic clear(input logic [11:0] base_w);
      foreach (mem[i]) mem[i] = 16'h0000;
      ring_w  = base_w;
      dev_idx = 0;
   endtask : clear

   // words 1 and 2 and the address byte are never written here
   task automatic fill(input logic [2:0] ftype, input logic last, input logic err, input logic [15:0] msg);
      logic [11:0] w;
      w = ring_w + 12'(dev_idx * 4);
      mem[w + 3] = last ? -msg : 16'hdead;
      mem[w] = {1'b0, mem[w][14], 1'b0, last, ftype, err, mem[w][7:0]};
      dev_idx = mem[w][14] ? 0 : dev_idx + 1;
   endtask : fill

   // data lines toggle when idle so a stale read cannot pass
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_ack <= 1'b0;
         wait_cnt  <= 0;
      end else begin
         o_mem_ack   <= 1'b0;
         o_mem_rdata <= ~o_mem_rdata;
         if (i_mem_req && !o_mem_ack) begin
            if (wait_cnt >= slow) begin
               o_mem_ack <= 1'b1;
               wait_cnt  <= 0;
               if (i_mem_we) begin
                  mem[i_mem_addr[12:1]] <= i_mem_wdata;
               end else begin
                  o_mem_rdata <= mem[i_mem_addr[12:1]];
               end
            end else begin
               wait_cnt <= wait_cnt + 1;
            end
         end
      end
   end
endmodule : rx_dev_model

// >>> tb/tb.sv
// Purpose: self-checking bench for the receive ring host controller
// Assumes: ring at byte 0x100, buffers at 0x120400
// Notes:   second run uses a one-entry ring with bad-frame keeping off
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     i_ref_clk, i_rst, i_start, i_keep_bad_frames_enable, i_release;
   logic [6:0]               i_ring_last;
   logic [23:0]              i_ring_base, i_buf_base, o_mem_addr;
   logic [15:0]              i_buf_len, o_mem_wdata, i_mem_rdata;
   logic                     o_busy, o_mem_req, o_mem_we, i_mem_ack;
   rx_ring_pkg::rx_report_t  o_rx;
   int                       mismatches, comparisons, k, idx;
   logic                     lst, err;

   rx_ring_host rx_ring_host_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(i_start),
      .i_ring_last(i_ring_last), .i_ring_base(i_ring_base), .i_buf_base(i_buf_base), .i_buf_len(i_buf_len),
      .i_keep_bad_frames_enable(i_keep_bad_frames_enable), .i_release(i_release), .o_rx(o_rx),
      .o_busy(o_busy), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
      .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata));

   rx_dev_model rx_dev_model_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mem_req(o_mem_req),
      .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .o_mem_ack(i_mem_ack),
      .o_mem_rdata(i_mem_rdata));

   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   task automatic do_reset();
      i_rst <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      check(33'({o_busy, o_mem_req, o_rx.valid}), 33'h0);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
   endtask : do_reset

   task automatic start_ring(input logic [6:0] last, input logic [15:0] len, input logic keep);
      i_ring_last              <= last;
      i_buf_len                <= len;
      i_keep_bad_frames_enable <= keep;
      i_start                  <= 1'b1;
      @(posedge i_ref_clk);
      i_start <= 1'b0;
      #1 check(33'(o_busy), 33'h1);
   endtask : start_ring

   // bounded wait until the host hands word 0 back to the device
   task automatic wait_word(input int w, input logic [15:0] exp);
      int n;
      n = 0;
      while (rx_dev_model_inst.mem[w][15] !== 1'b1 && n < 4000) begin
         @(posedge i_ref_clk);
         n++;
      end
      check(33'(rx_dev_model_inst.mem[w]), 33'(exp));
   endtask : wait_word

   // report is seen in its single valid cycle, then released
   task automatic expect_report(input logic [32:0] exp);
      int n;
      n = 0;
      while (o_rx.valid !== 1'b1 && n < 4000) begin
         @(posedge i_ref_clk);
         #1 n++;
      end
      check(o_rx, exp);
      @(posedge i_ref_clk);
      i_release <= 1'b1;
      @(posedge i_ref_clk);
      i_release <= 1'b0;
   endtask : expect_report

   initial begin
      repeat (60000) @(posedge i_ref_clk);
      mismatches++;
      complete_run();
   end

   initial begin
      i_rst = 1'b1;
      i_start = 1'b0;
      i_release = 1'b0;
      i_keep_bad_frames_enable = 1'b0;
      i_ring_last = 7'h00;
      i_buf_len = 16'h0000;
      i_ring_base = 24'h000100;
      i_buf_base = 24'h120400;
      mismatches = 0;
      comparisons = 0;
      k = 0;
      rx_dev_model_inst.clear(12'h080);
      do_reset();
      // odd length is made even
      start_ring(7'h02, 16'h0021, 1'b1);
      wait_word(12'h088, 16'hc012);
      for (int n = 0; n < 3; n++) begin
         check(33'(rx_dev_model_inst.mem[12'h080 + 4*n]), 33'({1'b1, n == 2, 14'h0012}));
         check(33'(rx_dev_model_inst.mem[12'h081 + 4*n]), 33'(16'h0400 + 16'(n * 32)));
         check(33'(rx_dev_model_inst.mem[12'h082 + 4*n]), 33'(16'hffe0));
         check(33'(rx_dev_model_inst.mem[12'h083 + 4*n]), 33'h0);
      end
      // every defined frame type, one chained buffer, prompt and slow memory, two wraps
      for (int i = 0; i < 8; i++) begin
         if (i != 1) begin
            lst = (i != 5);
            err = i[0];
            idx = k % 3;
            rx_dev_model_inst.slow = (k % 2) * 3;
            rx_dev_model_inst.fill(3'(i), lst, err, 16'(2 * i + 6));
            expect_report({1'b1, err, lst, 3'(i), 7'(idx), lst ? 16'(2 * i + 6) : 16'h0020});
            wait_word(12'h080 + 4 * idx, {1'b1, idx == 2, 14'h0012});
            check(33'(rx_dev_model_inst.mem[12'h082 + 4*idx]), 33'(16'hffe0));
            k++;
         end
      end
      // short length is raised, error flag hidden, single entry wraps to itself
      // clear only once the host is held idle, a live poll must not see an emptied ring
      rx_dev_model_inst.slow = 1;
      do_reset();
      rx_dev_model_inst.clear(12'h080);
      start_ring(7'h00, 16'h000b, 1'b0);
      wait_word(12'h080, 16'hc012);
      check(33'(rx_dev_model_inst.mem[12'h082]), 33'(16'hfff0));
      rx_dev_model_inst.fill(3'h7, 1'b0, 1'b1, 16'h0008);
      expect_report({1'b1, 1'b0, 1'b0, 3'h7, 7'h00, 16'h0010});
      wait_word(12'h080, 16'hc012);
      rx_dev_model_inst.fill(3'h2, 1'b1, 1'b1, 16'h000c);
      expect_report({1'b1, 1'b0, 1'b1, 3'h2, 7'h00, 16'h000c});
      wait_word(12'h080, 16'hc012);
      complete_run();
   end
endmodule : tb
